//--- bench/auqs_dev_model.sv
// peripheral model: plug, unplug and enumeration reports
// assumes the switch samples enum_info only in the enum_valid cycle
`timescale 1ns/1ps
module auqs_dev_model
    import auqs_pkg::*;
(
    input wire logic sys_clk,
    output logic dev_attach,
    output logic enum_valid,
    output auqs_enum_t enum_info
);
    initial
    begin
        dev_attach = 1'b0;
        enum_valid = 1'b0;
        enum_info = '0;
    end

    // ids and serial arbitrary
    task send(input logic [7:0] cls, input logic [15:0] rev);
        @(posedge sys_clk);
        enum_valid <= 1'b1;
        enum_info <= '{cls: cls, sub: 8'h00, proto: 8'h00, vid: 16'hA5A5, pid: 16'h5A5A,
            serial: 32'h0000_0042, usb_ver: USB_V20, ccid_rev: rev, bus_pwr: 1'b1};
        @(posedge sys_clk);
        enum_valid <= 1'b0;
        // stale results inverted, nothing may lean on the last value
        enum_info <= ~enum_info;
    endtask

    task plug(input logic [7:0] cls, input logic [15:0] rev);
        @(posedge sys_clk);
        dev_attach <= 1'b1;
        repeat (6) @(posedge sys_clk);
        send(cls, rev);
    endtask

    task unplug;
        @(posedge sys_clk);
        dev_attach <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the auth usb qualify switch
// assumes short dip and blink counts and the peripheral model on the far side
`timescale 1ns/1ps
module tb_top
    import auqs_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset, pready, pslverr, dev_attach, enum_valid, tamper_in, selftest_done, selftest_pass;
    logic btn_freeze, btn_restore, route_qual, route_host, vbus_en, vbus_shunt, freeze_led, selftest_req;
    logic [NCH-1:0] btn_sel, host_en, sel_led;
    logic [31:0] prdata, rd;
    logic [12:0] outs;
    logic err;
    auqs_apb_t apb_req;
    auqs_enum_t enum_info;
    int n_mismatch = 0;
    int comparisons = 0;

    assign outs = {route_qual, route_host, host_en, vbus_en, vbus_shunt, sel_led, freeze_led};
    always #5 sys_clk = ~sys_clk;

    auqs_top #(.DIP_CYC(8), .BLINK_CYC(4)) DUT (.sys_clk(sys_clk), .reset(reset), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_attach(dev_attach),
        .enum_valid(enum_valid), .enum_info(enum_info), .tamper_in(tamper_in),
        .selftest_done(selftest_done), .selftest_pass(selftest_pass), .btn_sel(btn_sel),
        .btn_freeze(btn_freeze), .btn_restore(btn_restore), .route_qual(route_qual),
        .route_host(route_host), .host_en(host_en), .vbus_en(vbus_en), .vbus_shunt(vbus_shunt),
        .sel_led(sel_led), .freeze_led(freeze_led), .selftest_req(selftest_req));

    auqs_dev_model u_dev (.sys_clk(sys_clk), .dev_attach(dev_attach), .enum_valid(enum_valid),
        .enum_info(enum_info));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task conclude;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task expire;
        n_mismatch++;
        conclude;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wcyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task pass_test;
        @(posedge sys_clk);
        selftest_done <= 1'b1;
        selftest_pass <= 1'b1;
        @(posedge sys_clk);
        selftest_done <= 1'b0;
        wcyc(2);
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
            expire;
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask

    // k 0 waits on route_host, k 1 on vbus_en, k 2 on selftest_req
    task wait_for(input int k, input logic v);
        int i;
        for (i = 0; i < 40 && (k == 0 ? route_host : k == 1 ? vbus_en : selftest_req) !== v; i++)
            @(posedge sys_clk);
        if ((k == 0 ? route_host : k == 1 ? vbus_en : selftest_req) !== v)
            expire;
    endtask

    // k below NCH picks a channel, NCH freeze, NCH+1 restore
    task press(input int k);
        logic [NCH+1:0] one;
        one = {{(NCH+1){1'b0}}, 1'b1};
        @(posedge sys_clk);
        {btn_restore, btn_freeze, btn_sel} <= one << k;
        wcyc(4);
        {btn_restore, btn_freeze, btn_sel} <= '0;
        wcyc(4);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        apb_req = '0;
        tamper_in = 1'b0;
        selftest_done = 1'b0;
        selftest_pass = 1'b0;
        btn_sel = '0;
        btn_freeze = 1'b0;
        btn_restore = 1'b0;
        wcyc(16);
        chk("outs_in_reset", outs, 32'h0000_1000);
        reset <= 1'b0;
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped_err", err, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b1, OFS_FCLS, 32'h0100_000B);
        apb(1'b0, OFS_FCLS, 32'h0000_0000);
        chk("fcls_locked", rd, 32'h0);
        press(0);
        chk("outs_before_test", outs, 32'h0000_1040);
        pass_test;
        apb(1'b0, OFS_STAT, 32'h0000_0000);
        chk("stat_run", rd & 32'h0000_0003, 32'h1);
        press(0);
        chk("first_dip", {vbus_en, vbus_shunt}, 32'h1);
        wait_for(1, 1'b1);
        chk("sel_led", sel_led, 32'h1);
        u_dev.plug(8'h0B, REV_CCID);
        wait_for(0, 1'b1);
        chk("route_qual", route_qual, 32'h0);
        chk("host_ch0", host_en, 32'h1);
        press(2);
        chk("dip_cut", {host_en, vbus_en, vbus_shunt}, 32'h1);
        wait_for(1, 1'b1);
        u_dev.send(8'h0B, REV_CCID);
        wait_for(0, 1'b1);
        chk("host_ch2", host_en, 32'h4);
        // non smart-card class during the session
        u_dev.send(8'h03, REV_CCID);
        wait_for(0, 1'b0);
        chk("reject", {route_qual, host_en}, 32'h10);
        chk("reject_blocked", host_en, 32'h0);
        u_dev.send(8'h0B, REV_CCID);
        wcyc(4);
        chk("reject_held", {route_qual, route_host}, 32'h2);
        u_dev.unplug;
        u_dev.plug(8'h0B, REV_ICCID);
        wait_for(0, 1'b1);
        chk("iccid_host", host_en, 32'h4);
        press(NCH);
        chk("freeze_led", freeze_led, 32'h1);
        press(1);
        chk("frozen", {host_en, vbus_en, sel_led}, 32'h94);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0401);
        wcyc(2);
        chk("denied", {route_host, host_en}, 32'h10);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_0401);
        // allow entry on class 03 replaces the smart-card baseline
        apb(1'b1, OFS_FCLS, 32'h0100_0003);
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        u_dev.send(8'h03, REV_CCID);
        wcyc(2);
        chk("allow_hit", {route_host, host_en}, 32'h14);
        u_dev.send(8'h0B, REV_CCID);
        wait_for(0, 1'b0);
        chk("allow_miss", {route_qual, host_en}, 32'h10);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("cfg_mode", rd, 32'h0000_0003);
        u_dev.unplug;
        press(NCH + 1);
        chk("restore_blink", {host_en, sel_led}, 32'h0F);
        wait_for(2, 1'b1);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("restored", rd, 32'h0000_0001);
        chk("retest_dark", {sel_led, freeze_led}, 32'h0);
        pass_test;
        press(1);
        wait_for(1, 1'b1);
        chk("sel_ch1", sel_led, 32'h2);
        u_dev.plug(8'h03, REV_CCID);
        apb(1'b0, OFS_STAT, 32'h0000_0000);
        chk("fixed_reject", rd & 32'h0000_000C, 32'hC);
        u_dev.unplug;
        u_dev.plug(8'h0B, REV_CCID);
        wait_for(0, 1'b1);
        chk("host_ch1", host_en, 32'h2);
        tamper_in <= 1'b1;
        wcyc(6);
        chk("tamper", {route_host, host_en}, 32'h10);
        conclude;
    end
endmodule

//--- rtl/auqs_pkg.sv
// shared constants, types and register map of the auth usb qualify switch
// assumes a 100 MHz system clock and an apb master on the same clock
package auqs_pkg;
    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NCH = 4;
    localparam int SELW = 2;
    localparam int CLK_MHZ = 100;
    localparam int DIP_TIME_MS = 100;
    localparam int DIP_CYCLES = DIP_TIME_MS * CLK_MHZ * 1000;
    localparam int BLINK_TIME_MS = 250;
    localparam int BLINK_CYCLES = BLINK_TIME_MS * CLK_MHZ * 1000;
    localparam logic [3:0] BLINK_FLASHES = 4'h6;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_FCLS = 12'h004;
    localparam logic [11:0] OFS_FID = 12'h008;
    localparam logic [11:0] OFS_FSER = 12'h00C;
    localparam logic [11:0] OFS_STAT = 12'h010;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam int CTRL_ADMIN = 0;
    localparam int CTRL_LOAD = 1;
    localparam int CTRL_DENY = 2;
    localparam int CTRL_MASK = 8;
    localparam int FCLS_EN = 24;

    // ------------------------------------------------------------
    // qualification constants
    // ------------------------------------------------------------
    localparam logic [7:0] CCID_CLASS = 8'h0B;
    localparam logic [15:0] REV_CCID = 16'h0110;
    localparam logic [15:0] REV_ICCID = 16'h0100;
    localparam logic [15:0] USB_V11 = 16'h0110;
    localparam logic [15:0] USB_V20 = 16'h0200;
    localparam logic [15:0] USB_V30 = 16'h0300;

    // synchronised pin vector layout, channel select buttons in the low bits
    localparam int PIN_ATT = NCH;
    localparam int PIN_TMP = NCH + 1;
    localparam int PIN_FRZ = NCH + 2;
    localparam int PIN_RST = NCH + 3;
    localparam int PINW = NCH + 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SYS_TEST, SYS_RUN, SYS_BLINK, SYS_FAIL} auqs_sys_t;
    typedef enum logic [1:0] {P_DET, P_QUAL, P_PASS, P_REJ} auqs_port_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } auqs_apb_t;

    typedef struct packed {
        logic [7:0] cls;
        logic [7:0] sub;
        logic [7:0] proto;
        logic [15:0] vid;
        logic [15:0] pid;
        logic [31:0] serial;
        logic [15:0] usb_ver;
        logic [15:0] ccid_rev;
        logic bus_pwr;
    } auqs_enum_t;
endpackage

//--- rtl/auqs_top.sv
// auth usb qualify switch: qualifier routing, host mux, power dip, panel
// assumes enumeration results come from same-clock qualifier logic; panel
// pins, attach detect and tamper are asynchronous and synchronised here
`timescale 1ns/1ps

module auqs_top
    import auqs_pkg::*;
#(
    parameter int DIP_CYC = DIP_CYCLES,
    parameter int BLINK_CYC = BLINK_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire auqs_apb_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dev_attach,
    input wire logic enum_valid,
    input wire auqs_enum_t enum_info,
    input wire logic tamper_in,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    input wire logic [NCH-1:0] btn_sel,
    input wire logic btn_freeze,
    input wire logic btn_restore,
    output logic route_qual,
    output logic route_host,
    output logic [NCH-1:0] host_en,
    output logic vbus_en,
    output logic vbus_shunt,
    output logic [NCH-1:0] sel_led,
    output logic freeze_led,
    output logic selftest_req
);
    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [PINW-1:0] pin_s1_r;
    logic [PINW-1:0] pin_s2_r;
    logic [PINW-1:0] pin_d_r;
    logic [PINW-1:0] rise;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_d_r <= '0;
        end
        else
        begin
            pin_s1_r <= {btn_restore, btn_freeze, tamper_in, dev_attach, btn_sel};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    assign rise = pin_s2_r & ~pin_d_r;

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    auqs_sys_t sys_r;
    auqs_port_t port_r;
    logic tamp_r;
    logic admin_r;
    logic cfg_mode_r;
    logic deny_rule_r;
    logic [NCH-1:0] deny_mask_r;
    logic [5:0] crit_en_r;
    logic [7:0] f_cls_r;
    logic [7:0] f_sub_r;
    logic [7:0] f_pro_r;
    logic [15:0] f_vid_r;
    logic [15:0] f_pid_r;
    logic [31:0] f_ser_r;
    logic [SELW-1:0] sel_r;
    logic chan_valid_r;
    logic frz_r;
    logic [31:0] dip_cnt_r;
    logic [31:0] dip_cnt_nxt;
    logic [31:0] blink_cnt_r;
    logic [3:0] blink_n_r;
    logic blink_ph_r;
    logic blink_done;
    logic restore_go;
    logic dip_go;
    logic path_ok;
    logic attached;

    assign attached = pin_s2_r[PIN_ATT];
    assign restore_go = sys_r == SYS_RUN && rise[PIN_RST];
    assign blink_done = blink_cnt_r == '0 && blink_n_r == BLINK_FLASHES - 4'h1;

    // ------------------------------------------------------------
    // apb slave: one wait state, error on unmapped offsets
    // ------------------------------------------------------------
    logic acc;
    logic mapped;
    logic wr_en;
    logic [31:0] rdata;

    assign acc = apb_req.psel && apb_req.penable;
    assign mapped = apb_req.paddr inside {OFS_CTRL, OFS_FCLS, OFS_FID, OFS_FSER, OFS_STAT};
    assign wr_en = acc && pready && apb_req.pwrite && mapped;

    always_comb
    begin
        rdata = REG_RST;
        case (apb_req.paddr)
            OFS_CTRL: rdata = {20'h0_0000, deny_mask_r, 5'h00, deny_rule_r, cfg_mode_r, admin_r};
            OFS_FCLS: rdata = {2'h0, crit_en_r, f_pro_r, f_sub_r, f_cls_r};
            OFS_FID: rdata = {f_pid_r, f_vid_r};
            OFS_FSER: rdata = f_ser_r;
            OFS_STAT: rdata = {22'h00_0000, frz_r, chan_valid_r, sel_r, tamp_r, vbus_shunt, port_r, sys_r};
            default: rdata = REG_RST;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            prdata <= REG_RST;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= acc && !pready;
            prdata <= (acc && !pready && !apb_req.pwrite) ? rdata : REG_RST;
            pslverr <= acc && !pready && !mapped;
        end
    end

    // ------------------------------------------------------------
    // filter registers; restore returns them to factory values
    // ------------------------------------------------------------
    // admin login flag survives restore: credentials are kept
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            admin_r <= 1'b0;
        else if (wr_en && apb_req.paddr == OFS_CTRL)
            admin_r <= apb_req.pwdata[CTRL_ADMIN];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || restore_go)
        begin
            cfg_mode_r <= 1'b0;
            deny_rule_r <= 1'b0;
            deny_mask_r <= '0;
            crit_en_r <= '0;
            f_cls_r <= '0;
            f_sub_r <= '0;
            f_pro_r <= '0;
            f_vid_r <= '0;
            f_pid_r <= '0;
            f_ser_r <= '0;
        end
        else if (wr_en && admin_r)
        begin
            case (apb_req.paddr)
                OFS_CTRL:
                begin
                    if (apb_req.pwdata[CTRL_LOAD])
                        cfg_mode_r <= 1'b1;
                    deny_rule_r <= apb_req.pwdata[CTRL_DENY];
                    deny_mask_r <= apb_req.pwdata[CTRL_MASK +: NCH];
                end
                OFS_FCLS:
                begin
                    f_cls_r <= apb_req.pwdata[7:0];
                    f_sub_r <= apb_req.pwdata[15:8];
                    f_pro_r <= apb_req.pwdata[23:16];
                    crit_en_r <= apb_req.pwdata[FCLS_EN +: 6];
                end
                OFS_FID:
                begin
                    f_vid_r <= apb_req.pwdata[15:0];
                    f_pid_r <= apb_req.pwdata[31:16];
                end
                OFS_FSER: f_ser_r <= apb_req.pwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // qualification match
    // ------------------------------------------------------------
    logic fixed_ok;
    logic ver_ok;
    logic [5:0] crit_eq;
    logic filt_hit;
    logic pass_ok;

    assign fixed_ok = enum_info.cls == CCID_CLASS && enum_info.bus_pwr
        && (enum_info.ccid_rev == REV_CCID || enum_info.ccid_rev == REV_ICCID);
    assign ver_ok = enum_info.usb_ver inside {USB_V11, USB_V20, USB_V30};
    assign crit_eq = {enum_info.serial == f_ser_r, enum_info.vid == f_vid_r,
        enum_info.pid == f_pid_r, enum_info.proto == f_pro_r,
        enum_info.sub == f_sub_r, enum_info.cls == f_cls_r};
    assign filt_hit = |crit_en_r && &(crit_eq | ~crit_en_r);
    // deny entries only narrow the auth-device baseline, never widen it
    assign pass_ok = !cfg_mode_r ? fixed_ok
        : (deny_rule_r ? (fixed_ok && !filt_hit) : (ver_ok && filt_hit));

    // ------------------------------------------------------------
    // port routing state
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset || !attached)
            port_r <= P_DET;
        else
        begin
            case (port_r)
                P_DET: port_r <= P_QUAL;
                P_QUAL:
                    if (enum_valid)
                        port_r <= pass_ok ? P_PASS : P_REJ;
                P_PASS:
                    if (dip_go)
                        port_r <= P_QUAL;
                    else if (enum_valid && !pass_ok)
                        port_r <= P_REJ;
                P_REJ: port_r <= P_REJ;
                default: port_r <= P_DET;
            endcase
        end
    end

    // lines are switched, never buffered, so nothing of the traffic is held
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            route_qual <= 1'b1;
            route_host <= 1'b0;
        end
        else
        begin
            route_qual <= port_r != P_PASS;
            route_host <= port_r == P_PASS;
        end
    end

    // ------------------------------------------------------------
    // system state: self-test, run, restore blink, fail
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tamp_r <= 1'b0;
        else if (pin_s2_r[PIN_TMP])
            tamp_r <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sys_r <= SYS_TEST;
        else if (tamp_r)
            sys_r <= SYS_FAIL;
        else
        begin
            case (sys_r)
                SYS_TEST:
                    if (selftest_done)
                        sys_r <= selftest_pass ? SYS_RUN : SYS_FAIL;
                SYS_RUN:
                    if (restore_go)
                        sys_r <= SYS_BLINK;
                SYS_BLINK:
                    if (blink_done)
                        sys_r <= SYS_TEST;
                SYS_FAIL: sys_r <= SYS_FAIL;
                default: sys_r <= SYS_TEST;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            selftest_req <= 1'b0;
        else
            selftest_req <= sys_r == SYS_BLINK && blink_done && !tamp_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset || restore_go)
        begin
            blink_cnt_r <= 32'(BLINK_CYC - 1);
            blink_n_r <= '0;
            blink_ph_r <= 1'b1;
        end
        else if (sys_r == SYS_BLINK)
        begin
            if (blink_cnt_r == '0)
            begin
                blink_cnt_r <= 32'(BLINK_CYC - 1);
                blink_n_r <= blink_n_r + 4'h1;
                blink_ph_r <= !blink_ph_r;
            end
            else
                blink_cnt_r <= blink_cnt_r - 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // channel selection, freeze and power dip
    // ------------------------------------------------------------
    logic pick_v;
    logic [SELW-1:0] pick;

    // lowest pressed button wins when several rise together
    always_comb
    begin
        pick_v = 1'b0;
        pick = '0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (rise[i])
            begin
                pick_v = 1'b1;
                pick = SELW'(i);
            end
        end
    end

    assign dip_go = sys_r == SYS_RUN && !tamp_r && !frz_r && pick_v
        && (!chan_valid_r || pick != sel_r);

    always_ff @(posedge sys_clk)
    begin
        if (reset || sys_r != SYS_RUN)
        begin
            sel_r <= '0;
            chan_valid_r <= 1'b0;
            frz_r <= 1'b0;
        end
        else
        begin
            if (dip_go)
            begin
                sel_r <= pick;
                chan_valid_r <= 1'b1;
            end
            if (rise[PIN_FRZ])
                frz_r <= !frz_r;
        end
    end

    always_comb
    begin
        if (dip_go)
            dip_cnt_nxt = 32'(DIP_CYC);
        else if (dip_cnt_r != '0)
            dip_cnt_nxt = dip_cnt_r - 32'h0000_0001;
        else
            dip_cnt_nxt = '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            dip_cnt_r <= '0;
            vbus_en <= 1'b0;
            vbus_shunt <= 1'b0;
            freeze_led <= 1'b0;
        end
        else
        begin
            dip_cnt_r <= dip_cnt_nxt;
            vbus_en <= dip_cnt_nxt == '0;
            vbus_shunt <= dip_cnt_nxt != '0;
            freeze_led <= frz_r && sys_r == SYS_RUN;
        end
    end

    // ------------------------------------------------------------
    // per-channel host paths and indicators
    // ------------------------------------------------------------
    assign path_ok = sys_r == SYS_RUN && !tamp_r && !pin_s2_r[PIN_TMP]
        && port_r == P_PASS && chan_valid_r && dip_cnt_r == '0;

    // each channel owns its flops; nothing is shared between channels
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        always_ff @(posedge sys_clk)
        begin
            if (reset)
            begin
                host_en[g] <= 1'b0;
                sel_led[g] <= 1'b0;
            end
            else
            begin
                host_en[g] <= path_ok && sel_r == SELW'(g) && !deny_mask_r[g];
                sel_led[g] <= (sys_r == SYS_RUN && chan_valid_r && sel_r == SELW'(g))
                    || (sys_r == SYS_BLINK && blink_ph_r);
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_FIXED_ONLY:
        assert property (port_r == P_QUAL && attached && enum_valid && !cfg_mode_r && !fixed_ok
            |=> port_r == P_REJ)
        else $error("fixed mode passed a non-ccid device");
    AST_CFG_ADMIN:
        assert property ($rose(cfg_mode_r) |-> $past(admin_r))
        else $error("configurable mode entered without admin");
    AST_ATTACH_QUAL:
        assert property ($rose(attached) |=> ##1 route_qual && !route_host)
        else $error("attach not routed to qualifier");
    AST_PASS_ROUTE:
        assert property (port_r == P_PASS |=> route_host && !route_qual)
        else $error("qualified device not on host mux");
    AST_SESSION_REJ:
        assert property (port_r == P_PASS && attached && enum_valid && !pass_ok && !dip_go
            |=> port_r == P_REJ ##1 !route_host)
        else $error("mismatch during session not rejected");
    AST_DIP:
        assert property (dip_go |=> (vbus_shunt && !vbus_en)[*2])
        else $error("channel change did not dip port power");
    AST_ISOLATE:
        assert property (pin_s2_r[PIN_TMP] || sys_r == SYS_FAIL |=> host_en == '0)
        else $error("path open after tamper or test failure");
    AST_DENY:
        assert property ((host_en & $past(deny_mask_r)) == '0)
        else $error("denied channel routed");
    AST_FREEZE:
        assert property (frz_r && sys_r == SYS_RUN && !restore_go |=> $stable(sel_r) ##0 freeze_led)
        else $error("selection moved while frozen");
    AST_NO_IND:
        assert property (sys_r == SYS_TEST |=> sel_led == '0 && host_en == '0)
        else $error("indication before self-test pass");
    AST_LED_ON:
        assert property (sys_r == SYS_RUN && chan_valid_r |=> sel_led != '0)
        else $error("selection indicator dark while running");
    AST_RESTORE:
        assert property (restore_go && !tamp_r |=> sys_r == SYS_BLINK ##1 host_en == '0)
        else $error("restore did not disconnect and blink");
    AST_REJ_HOLD:
        assert property (port_r == P_REJ && attached |=> port_r == P_REJ ##0 route_qual)
        else $error("rejected device left qualifier");
endmodule
